/* inc/csc_pkg.sv */
// package for the clock source control block: register map, fields, reset values, counts
// assumes a byte-wide register port and a 25 MHz system clock
package csc_pkg;

    // ========================================
    // register offsets
    localparam logic [15:0] OSC_CTRL_ADDR   = 16'h303E;
    localparam logic [15:0] ICU_CTRL_ADDR   = 16'h3038;
    localparam logic [15:0] ICU_DIV_ADDR    = 16'h3039;
    localparam logic [15:0] ICU_CTRIM_ADDR  = 16'h303A;
    localparam logic [15:0] ICU_FTRIM_ADDR  = 16'h303B;
    localparam logic [15:0] ICU_STAT_ADDR   = 16'h303C;

    // ========================================
    // oscillator control fields
    localparam int OSC_EN_BIT    = 7;
    localparam int OSC_STEN_BIT  = 5;
    localparam int OSC_OS_BIT    = 4;
    localparam int OSC_RANGE_BIT = 2;
    localparam int OSC_GAIN_BIT  = 1;
    localparam int OSC_INIT_BIT  = 0;
    localparam logic [7:0] OSC_WR_MASK    = 8'hB6;
    localparam logic [7:0] OSC_CTRL_RESET = 8'h00;

    // ========================================
    // internal clock unit fields
    localparam int ICU_REFCKEN_BIT  = 7;
    localparam int ICU_REFSTOP_BIT  = 6;
    localparam int ICU_LLIRQ_BIT    = 5;
    localparam int ICU_MON_BIT      = 4;
    localparam int ICU_LP_BIT       = 3;
    localparam int ICU_IREFS_BIT    = 2;
    localparam int ICU_CLKS_LSB     = 0;
    localparam int STAT_LOSS_BIT    = 7;
    localparam int STAT_LOCK_BIT    = 6;
    localparam logic [7:0] ICU_CTRL_RESET = 8'h84;
    localparam logic [7:0] ICU_DIV_RESET  = 8'h00;

    // ========================================
    // counts
    localparam int CRYSTAL_DRIVE_PIN_STABLE_COUNT = 4096;
    localparam int FFCLK_MIN_RATIO   = 4;
    localparam logic [7:0] FACTORY_CTRIM_DEFAULT = 8'h80; // arbitrary
    localparam logic       FACTORY_FTRIM_DEFAULT = 1'b0;  // arbitrary

    typedef enum logic [2:0] {
        CSC_ENI, CSC_ENE, CSC_BPI, CSC_BPILP, CSC_BPE, CSC_BPELP
    } csc_mode_t;

    typedef enum logic [1:0] {
        CSC_OSC_OFF, CSC_OSC_START, CSC_OSC_STABLE, CSC_OSC_EXT
    } csc_osc_state_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        wr;
        logic        rd;
    } csc_bus_t;

endpackage

/* testbench/csc_crystal_drive_pin_model.sv */
// model of the crystal and the external clock source at the oscillator pins
// assumes the drive enable is low while the amplifier drives the crystal
`timescale 1ns/1ps
module csc_crystal_drive_pin_model #(
    parameter time CRYSTAL_DRIVE_PIN_HALF = 120,
    parameter time EXT_HALF  = 70
) (
    input  wire logic drive_oe_n_in,
    output logic      raw_clock_out,
    output logic      ext_pin_out
);
    // ==========
    // clock sources
    initial raw_clock_out = 1'b0;
    initial ext_pin_out = 1'b0;
    // a canned source on the pin runs free
    always #EXT_HALF ext_pin_out = ~ext_pin_out;
    // crystal swings only while driven, no amplitude means no edges
    always begin
        #CRYSTAL_DRIVE_PIN_HALF;
        raw_clock_out = (drive_oe_n_in === 1'b0) ? ~raw_clock_out : 1'b0;
    end
endmodule

/* testbench/csc_top_asserts.sv */
// checker for csc_top: register port, clock gating and lock flag properties
// assumes it is bound to csc_top and sees only its ports
`timescale 1ns/1ps
module csc_chk (
    input wire logic        CLK_SYS_IN,
    input wire logic        RST_IN,
    input wire logic [15:0] ADDR_IN,
    input wire logic [7:0]  WDATA_IN,
    input wire logic        WR_IN,
    input wire logic        RD_IN,
    input wire logic [7:0]  RDATA_OUT,
    input wire logic        FLL_LOCKED_IN,
    input wire logic        CLOCK_UNIT_CRYSTAL_REQUEST_IN,
    input wire logic        CRYSTAL_CLOCK_OUT,
    input wire logic        CRYSTAL_HIGH_GAIN_OUT,
    input wire logic        INTERNAL_REF_CLOCK_OUT,
    input wire logic        LOCK_REF_EXTERNAL_OUT,
    input wire logic [7:0]  INT_REF_COARSE_TRIM_OUT,
    input wire logic        LOSS_OF_LOCK_IRQ_OUT
);
    // ==========
    // decodes and a counter of steady lock cycles
    wire        osc_wr = WR_IN && ADDR_IN == csc_pkg::OSC_CTRL_ADDR;
    wire        icu_wr = WR_IN && ADDR_IN == csc_pkg::ICU_CTRL_ADDR;
    wire        mapped = ADDR_IN == csc_pkg::OSC_CTRL_ADDR ||
        (ADDR_IN >= csc_pkg::ICU_CTRL_ADDR && ADDR_IN <= csc_pkg::ICU_STAT_ADDR);
    wire        gain_w = WDATA_IN[csc_pkg::OSC_GAIN_BIT];
    logic [3:0] run_q;
    logic [3:0] run_d;
    // saturates so a long lock never wraps back to a small count
    always_comb begin
        run_d = !FLL_LOCKED_IN ? 4'h0 : (run_q == 4'hF ? run_q : run_q + 4'h1);
    end
    always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
        if (RST_IN)
            run_q <= 4'h0;
        else
            run_q <= run_d;
    end
    default clocking @(posedge CLK_SYS_IN); endclocking
    default disable iff (RST_IN);
    // ==========
    // steps: a register write, then quiet or locked cycles
    sequence s_ref_off;
        icu_wr && !WDATA_IN[7] ##1 !icu_wr [*2];
    endsequence
    sequence s_int_ref;
        icu_wr && WDATA_IN[2] ##1 !icu_wr [*2];
    endsequence
    sequence s_ext_ref;
        icu_wr && WDATA_IN[2:0] == 3'h0 ##1 !icu_wr [*2];
    endsequence
    sequence s_osc_off;
        osc_wr && !WDATA_IN[7] ##1 (!osc_wr && !CLOCK_UNIT_CRYSTAL_REQUEST_IN) [*4];
    endsequence
    sequence s_lol_clear;
        WR_IN && ADDR_IN == csc_pkg::ICU_STAT_ADDR && WDATA_IN[7] && run_q > 4'h5
            ##1 FLL_LOCKED_IN [*2];
    endsequence
    // ==========
    // properties
    chk_rsvd_read:
        assert property (RD_IN && ADDR_IN == csc_pkg::OSC_CTRL_ADDR |=> !RDATA_OUT[6] && !RDATA_OUT[3])
        else $error("reserved bit read as one");
    chk_unmapped_zero:
        assert property (RD_IN && !mapped |=> RDATA_OUT == 8'h00)
        else $error("unmapped read not zero");
    chk_gain_copy:
        assert property (osc_wr |-> ##2 CRYSTAL_HIGH_GAIN_OUT == $past(gain_w, 2))
        else $error("gain output does not follow write");
    chk_trim_copy:
        assert property (WR_IN && ADDR_IN == csc_pkg::ICU_CTRIM_ADDR
            |-> ##2 INT_REF_COARSE_TRIM_OUT == $past(WDATA_IN, 2))
        else $error("coarse trim does not follow write");
    chk_ref_off:
        assert property (s_ref_off |=> !INTERNAL_REF_CLOCK_OUT)
        else $error("reference clock runs while disabled");
    chk_lock_ref_int:
        assert property (s_int_ref |=> !LOCK_REF_EXTERNAL_OUT)
        else $error("internal mode locks on external reference");
    chk_lock_ref_ext:
        assert property (s_ext_ref |=> LOCK_REF_EXTERNAL_OUT)
        else $error("external mode locks on internal reference");
    chk_osc_static:
        assert property (s_osc_off |=> !CRYSTAL_CLOCK_OUT)
        else $error("oscillator output active while disabled");
    chk_lol_clear:
        assert property (s_lol_clear |=> !LOSS_OF_LOCK_IRQ_OUT)
        else $error("lock loss flag not cleared by write one");
endmodule
bind csc_top csc_chk u_chk (
    .CLK_SYS_IN(CLK_SYS_IN), .RST_IN(RST_IN), .ADDR_IN(ADDR_IN), .WDATA_IN(WDATA_IN),
    .WR_IN(WR_IN), .RD_IN(RD_IN), .RDATA_OUT(RDATA_OUT), .FLL_LOCKED_IN(FLL_LOCKED_IN),
    .CLOCK_UNIT_CRYSTAL_REQUEST_IN(CLOCK_UNIT_CRYSTAL_REQUEST_IN),
    .CRYSTAL_CLOCK_OUT(CRYSTAL_CLOCK_OUT), .CRYSTAL_HIGH_GAIN_OUT(CRYSTAL_HIGH_GAIN_OUT),
    .INTERNAL_REF_CLOCK_OUT(INTERNAL_REF_CLOCK_OUT),
    .LOCK_REF_EXTERNAL_OUT(LOCK_REF_EXTERNAL_OUT),
    .INT_REF_COARSE_TRIM_OUT(INT_REF_COARSE_TRIM_OUT),
    .LOSS_OF_LOCK_IRQ_OUT(LOSS_OF_LOCK_IRQ_OUT)
);

/* testbench/tb.sv */
// self-checking bench for csc_top: registers, oscillator, lock flag, monitor
// assumes csc_crystal_drive_pin_model at the pins and the checker bound to csc_top
`timescale 1ns/1ps
module tb;
    typedef struct {
        logic [15:0] a;
        logic [7:0]  w;
        logic [7:0]  r;
        logic        stp;
        logic        rq;
        logic [1:0]  sl;
        logic        act;
    } csc_row_t;
    logic        clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, stop = 1'b0, ftrim = 1'b1;
    logic        lock = 1'b1, slow = 1'b0, ratio = 1'b0, req = 1'b0, xprev = 1'b0, a;
    logic [15:0] addr = 16'h0000;
    logic [7:0]  wdata = 8'h00, ctrim = 8'h5A, d;
    logic [1:0]  sel = 2'd3;
    logic [31:0] cyc = 32'h0, xedges = 32'h0, xs;
    int          err_total = 0, tests_run = 0, n;
    wire  [7:0]  rdata_o, ctrim_o;
    wire  [2:0]  bus_divider_o, ref_divider_o;
    wire         oe_n, xclk, gain, band, refclk, mainclk, ffv, lockext, ftrim_o, irq, crst;
    wire         xraw, xpin;
    wire         probe = sel == 2'd0 ? xclk : (sel == 2'd1 ? refclk : mainclk);
    csc_row_t    rows [17] = '{
        '{16'h303E, 8'h76, 8'h36, 1'b0, 1'b0, 2'd3, 1'b0},
        '{16'h303E, 8'h49, 8'h00, 1'b0, 1'b0, 2'd3, 1'b0},
        '{16'h3039, 8'h2D, 8'h2D, 1'b0, 1'b0, 2'd3, 1'b0},
        '{16'h303A, 8'h3C, 8'h3C, 1'b0, 1'b0, 2'd3, 1'b0},
        '{16'h303B, 8'h01, 8'h01, 1'b0, 1'b0, 2'd3, 1'b0},
        '{16'h3000, 8'hFF, 8'h00, 1'b0, 1'b0, 2'd3, 1'b0},
        '{16'h303E, 8'h80, 8'h81, 1'b0, 1'b0, 2'd0, 1'b1},
        '{16'h303E, 8'h80, 8'h80, 1'b1, 1'b0, 2'd0, 1'b0},
        '{16'h303E, 8'hA0, 8'hA1, 1'b1, 1'b0, 2'd0, 1'b1},
        '{16'h303E, 8'h80, 8'h81, 1'b1, 1'b1, 2'd0, 1'b1},
        '{16'h303E, 8'h00, 8'h01, 1'b0, 1'b1, 2'd0, 1'b1},
        '{16'h303E, 8'h00, 8'h00, 1'b0, 1'b0, 2'd0, 1'b0},
        '{16'h3038, 8'h84, 8'h84, 1'b0, 1'b0, 2'd1, 1'b1},
        '{16'h3038, 8'h04, 8'h04, 1'b0, 1'b0, 2'd1, 1'b0},
        '{16'h3038, 8'hC4, 8'hC4, 1'b1, 1'b0, 2'd1, 1'b1},
        '{16'h3038, 8'h84, 8'h84, 1'b1, 1'b0, 2'd1, 1'b0},
        '{16'h3038, 8'h85, 8'h85, 1'b0, 1'b0, 2'd2, 1'b1}
    };
    csc_top u_csc_top (.CLK_SYS_IN(clk), .RST_IN(rst), .ADDR_IN(addr), .WDATA_IN(wdata),
        .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata_o), .STOP_IN(stop), .BDM_IN(1'b0),
        .FACTORY_CTRIM_IN(ctrim), .FACTORY_FTRIM_IN(ftrim), .INT_REF_RAW_IN(cyc[1]),
        .FLL_CLOCK_IN(cyc[0]), .FLL_LOCKED_IN(lock), .EXT_REF_SLOW_IN(slow),
        .FFCLK_RAW_IN(cyc[2]), .FFCLK_RATIO_OK_IN(ratio), .CLOCK_UNIT_CRYSTAL_REQUEST_IN(req),
        .EXT_CLOCK_PIN_IN(xpin), .CRYSTAL_RAW_CLOCK_IN(xraw), .CRYSTAL_DRIVE_PIN_OUT(),
        .CRYSTAL_DRIVE_PIN_OE_N_OUT(oe_n), .CRYSTAL_CLOCK_OUT(xclk),
        .CRYSTAL_HIGH_GAIN_OUT(gain), .CRYSTAL_HIGH_BAND_OUT(band),
        .INTERNAL_REF_CLOCK_OUT(refclk), .MAIN_CLOCK_OUT(mainclk), .FIXED_FREQ_CLOCK_OUT(),
        .FIXED_FREQ_VALID_OUT(ffv), .LOCK_REF_EXTERNAL_OUT(lockext),
        .INT_REF_COARSE_TRIM_OUT(ctrim_o), .INT_REF_FINE_TRIM_OUT(ftrim_o),
        .BUS_DIVIDER_OUT(bus_divider_o), .REF_DIVIDER_OUT(ref_divider_o), .LOSS_OF_LOCK_IRQ_OUT(irq),
        .CHIP_RESET_REQ_OUT(crst));
    csc_crystal_drive_pin_model u_csc_crystal_drive_pin_model (.drive_oe_n_in(oe_n), .raw_clock_out(xraw),
        .ext_pin_out(xpin));
    // ==========
    // clock, raw clocks, crystal edge count, hang guard
    always #20 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 32'h1;
        xprev <= xraw;
        xedges <= xedges + {31'h0, xraw && !xprev};
        if (cyc == 32'd50000) begin
            err_total++;
            conclude();
        end
    end
    // ==========
    // bus tasks, comparison, activity probe
    task automatic conclude();
        $display("checks %0d errors %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic idle(input int c);
        repeat (c) @(posedge clk);
    endtask
    task automatic wr_reg(input logic [15:0] ad, input logic [7:0] v);
        @(posedge clk);
        addr <= ad;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [15:0] ad, output logic [7:0] v);
        @(posedge clk);
        addr <= ad;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 v = rdata_o;
    endtask
    task automatic activity(output logic seen);
        logic p;
        seen = 1'b0;
        p = probe;
        repeat (64) begin
            @(posedge clk);
            #1 seen = seen | (probe !== p);
            p = probe;
        end
    endtask
    // ==========
    // main sequence
    initial begin
        idle(20);
        rst <= 1'b0;
        idle(4);
        chk(ctrim_o, 8'h5A);
        rd_reg(16'h303E, d);
        chk(d, 8'h00);
        foreach (rows[i]) begin
            @(posedge clk);
            stop <= rows[i].stp;
            req <= rows[i].rq;
            sel = rows[i].sl;
            wr_reg(rows[i].a, rows[i].w);
            idle(8);
            rd_reg(rows[i].a, d);
            chk(d, rows[i].r);
            if (rows[i].sl != 2'd3) begin
                activity(a);
                chk({7'h00, a}, {7'h00, rows[i].act});
            end
        end
        chk({bus_divider_o, 2'h0, ref_divider_o}, 8'hA5);
        chk({7'h00, ftrim_o}, 8'h01);
        @(posedge clk);
        stop <= 1'b0;
        ratio <= 1'b1;
        wr_reg(16'h3038, 8'hA0);
        idle(8);
        chk({6'h00, ffv, lockext}, 8'h03);
        ratio <= 1'b0;
        wr_reg(16'h3038, 8'hA4);
        idle(8);
        chk({6'h00, ffv, lockext}, 8'h00);
        lock <= 1'b0;
        idle(8);
        chk({7'h00, irq}, 8'h01);
        wr_reg(16'h303C, 8'h00);
        lock <= 1'b1;
        idle(8);
        chk({7'h00, irq}, 8'h01);
        wr_reg(16'h303C, 8'h80);
        wr_reg(16'h3038, 8'hAD);
        lock <= 1'b0;
        idle(8);
        rd_reg(16'h303C, d);
        chk({d[7], 6'h00, irq}, 8'h00);
        lock <= 1'b1;
        slow <= 1'b1;
        wr_reg(16'h3038, 8'h94);
        idle(8);
        chk({7'h00, crst}, 8'h00);
        wr_reg(16'h3038, 8'h90);
        idle(8);
        chk({7'h00, crst}, 8'h01);
        // second reset mid-run with a new factory trim
        rst <= 1'b1;
        slow <= 1'b0;
        ctrim <= 8'hA5;
        ftrim <= 1'b0;
        idle(3);
        rst <= 1'b0;
        idle(4);
        chk({ctrim_o ^ 8'hA5} | {7'h00, ftrim_o | crst}, 8'h00);
        wr_reg(16'h303E, 8'h06);
        wr_reg(16'h303E, 8'h96);
        xs = xedges;
        idle(4);
        chk({6'h00, band, gain}, 8'h03);
        sel = 2'd0;
        n = 0;
        while (xedges - xs < 32'd4000 && n < 40000) begin
            idle(1);
            n++;
        end
        activity(a);
        chk({7'h00, a}, 8'h00);
        d = 8'h00;
        n = 0;
        while (d[0] !== 1'b1 && n < 2000) begin
            rd_reg(16'h303E, d);
            n++;
        end
        chk(d, 8'h97);
        chk({7'h00, xedges - xs >= 32'd4096 && xedges - xs <= 32'd4100}, 8'h01);
        activity(a);
        chk({7'h00, a}, 8'h01);
        wr_reg(16'h303E, 8'h06);
        idle(8);
        rd_reg(16'h303E, d);
        activity(a);
        chk({d[7:1], a}, 8'h06);
        conclude();
    end
endmodule

/* verilog/csc_top.sv */
// clock source control: register bank, reference clock gating, lock and monitor flags,
// crystal oscillator enable, stabilisation count and output select
// assumes raw clocks, lock and monitor status arrive unsynchronised from analog cells
//
// Functional notes
// - reference clock out when enable set
// - larger coarse trim means slower reference
// - trim affects main clock in internal modes
// - both stop enables keep reference in stop
// - factory trim loaded at every reset
// - fixed clock valid at most quarter main
// - external modes except BPELP lock against external reference
// - internal modes lock against internal reference
// - lock loss sets flag, optional interrupt
// - flag cleared by reset or write one
// - no lock detect in low power modes
// - monitor resets chip on slow external ref
// - oscillator on by bit or request
// - stop enable ignored under unit request
// - output select: pin or crystal
// - gain bit selects oscillator mode
// - init done reads one after count
// - bits six and three read zero
// - eight bit register, resets to zero
// - crystal clock gated for 4096 cycles
// - enable equation, outputs static when off
//
// Local design decision: the plain strobed port.
`timescale 1ns/1ps

module csc_top (
    input  wire logic        CLK_SYS_IN,
    input  wire logic        RST_IN,
    input  wire logic [15:0] ADDR_IN,
    input  wire logic [7:0]  WDATA_IN,
    input  wire logic        WR_IN,
    input  wire logic        RD_IN,
    output logic      [7:0]  RDATA_OUT,
    input  wire logic        STOP_IN,
    input  wire logic        BDM_IN,
    input  wire logic [7:0]  FACTORY_CTRIM_IN,
    input  wire logic        FACTORY_FTRIM_IN,
    input  wire logic        INT_REF_RAW_IN,
    input  wire logic        FLL_CLOCK_IN,
    input  wire logic        FLL_LOCKED_IN,
    input  wire logic        EXT_REF_SLOW_IN,
    input  wire logic        FFCLK_RAW_IN,
    input  wire logic        FFCLK_RATIO_OK_IN,
    input  wire logic        CLOCK_UNIT_CRYSTAL_REQUEST_IN,
    input  wire logic        EXT_CLOCK_PIN_IN,
    input  wire logic        CRYSTAL_RAW_CLOCK_IN,
    output logic             CRYSTAL_DRIVE_PIN_OUT,
    output logic             CRYSTAL_DRIVE_PIN_OE_N_OUT,
    output logic             CRYSTAL_CLOCK_OUT,
    output logic             CRYSTAL_HIGH_GAIN_OUT,
    output logic             CRYSTAL_HIGH_BAND_OUT,
    output logic             INTERNAL_REF_CLOCK_OUT,
    output logic             MAIN_CLOCK_OUT,
    output logic             FIXED_FREQ_CLOCK_OUT,
    output logic             FIXED_FREQ_VALID_OUT,
    output logic             LOCK_REF_EXTERNAL_OUT,
    output logic [7:0]       INT_REF_COARSE_TRIM_OUT,
    output logic             INT_REF_FINE_TRIM_OUT,
    output logic [2:0]       BUS_DIVIDER_OUT,
    output logic [2:0]       REF_DIVIDER_OUT,
    output logic             LOSS_OF_LOCK_IRQ_OUT,
    output logic             CHIP_RESET_REQ_OUT
);

    // ========================================
    // input synchronisers
    localparam int NSYNC = 10;
    logic [NSYNC-1:0] async_in;
    logic [NSYNC-1:0] sync1_q;
    logic [NSYNC-1:0] sync2_q;
    logic             stop_s, lock_s, slow_s, req_s, pin_s, xtl_s, iref_s, fll_s, ffc_s, ffok_s;

    assign async_in = {STOP_IN, FLL_LOCKED_IN, EXT_REF_SLOW_IN, CLOCK_UNIT_CRYSTAL_REQUEST_IN,
                       EXT_CLOCK_PIN_IN, CRYSTAL_RAW_CLOCK_IN, INT_REF_RAW_IN, FLL_CLOCK_IN,
                       FFCLK_RAW_IN, FFCLK_RATIO_OK_IN};
    assign {stop_s, lock_s, slow_s, req_s, pin_s, xtl_s, iref_s, fll_s, ffc_s, ffok_s} = sync2_q;

    // two flops per input, first flop feeds only the second
    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++) begin : g_sync
            always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
                if (RST_IN) begin
                    sync1_q[gi] <= 1'b0;
                    sync2_q[gi] <= 1'b0;
                end else begin
                    sync1_q[gi] <= async_in[gi];
                    sync2_q[gi] <= sync1_q[gi];
                end
            end
        end
    endgenerate

    // ========================================
    // mode decode
    function automatic csc_pkg::csc_mode_t mode_of(input logic [7:0] ctrl, input logic bdm);
        logic [1:0] clks;
        logic       lp;
        clks = ctrl[csc_pkg::ICU_CLKS_LSB +: 2];
        lp   = ctrl[csc_pkg::ICU_LP_BIT] & ~bdm;
        if (clks == 2'h0)
            mode_of = ctrl[csc_pkg::ICU_IREFS_BIT] ? csc_pkg::CSC_ENI : csc_pkg::CSC_ENE;
        else if (clks == 2'h1)
            mode_of = lp ? csc_pkg::CSC_BPILP : csc_pkg::CSC_BPI;
        else
            mode_of = lp ? csc_pkg::CSC_BPELP : csc_pkg::CSC_BPE;
    endfunction

    // ========================================
    // register state
    logic [7:0] osc_ctrl_q, osc_ctrl_d;
    logic [7:0] icu_ctrl_q, icu_ctrl_d;
    logic [7:0] icu_div_q,  icu_div_d;
    logic [7:0] ctrim_q,    ctrim_d;
    logic       ftrim_q,    ftrim_d;
    logic       lolf_q,     lolf_d;
    logic       lock_prev_q, lock_prev_d;
    logic       trim_load_q, trim_load_d;
    logic [7:0] rdata_q,    rdata_d;
    csc_pkg::csc_mode_t mode;
    logic       lock_active, lock_fall, wr_osc, wr_stat;

    assign mode        = mode_of(icu_ctrl_q, BDM_IN);
    assign lock_active = (mode != csc_pkg::CSC_BPILP) && (mode != csc_pkg::CSC_BPELP);
    assign lock_fall   = lock_active && lock_prev_q && !lock_s;
    assign wr_osc      = WR_IN && (ADDR_IN == csc_pkg::OSC_CTRL_ADDR);
    assign wr_stat     = WR_IN && (ADDR_IN == csc_pkg::ICU_STAT_ADDR);

    // register writes, trim upload and sticky lock flag
    always_comb begin
        osc_ctrl_d  = osc_ctrl_q;
        icu_ctrl_d  = icu_ctrl_q;
        icu_div_d   = icu_div_q;
        ctrim_d     = ctrim_q;
        ftrim_d     = ftrim_q;
        trim_load_d = 1'b0;
        lock_prev_d = lock_active ? lock_s : 1'b0;
        if (trim_load_q) begin
            ctrim_d = FACTORY_CTRIM_IN;
            ftrim_d = FACTORY_FTRIM_IN;
        end
        if (wr_osc)
            osc_ctrl_d = (WDATA_IN & csc_pkg::OSC_WR_MASK) | (osc_ctrl_q & ~csc_pkg::OSC_WR_MASK);
        if (WR_IN && ADDR_IN == csc_pkg::ICU_CTRL_ADDR)
            icu_ctrl_d = WDATA_IN;
        if (WR_IN && ADDR_IN == csc_pkg::ICU_DIV_ADDR)
            icu_div_d = {2'h0, WDATA_IN[5:0]};
        if (WR_IN && ADDR_IN == csc_pkg::ICU_CTRIM_ADDR)
            ctrim_d = WDATA_IN;
        if (WR_IN && ADDR_IN == csc_pkg::ICU_FTRIM_ADDR)
            ftrim_d = WDATA_IN[0];
        // set beats a same-cycle clear so no loss event is dropped
        lolf_d = lolf_q;
        if (wr_stat && WDATA_IN[csc_pkg::STAT_LOSS_BIT] && lolf_q)
            lolf_d = 1'b0;
        if (lock_fall)
            lolf_d = 1'b1;
    end

    always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
        if (RST_IN) begin
            osc_ctrl_q  <= csc_pkg::OSC_CTRL_RESET;
            icu_ctrl_q  <= csc_pkg::ICU_CTRL_RESET;
            icu_div_q   <= csc_pkg::ICU_DIV_RESET;
            ctrim_q     <= csc_pkg::FACTORY_CTRIM_DEFAULT;
            ftrim_q     <= csc_pkg::FACTORY_FTRIM_DEFAULT;
            lolf_q      <= 1'b0;
            lock_prev_q <= 1'b0;
            trim_load_q <= 1'b1;
        end else begin
            osc_ctrl_q  <= osc_ctrl_d;
            icu_ctrl_q  <= icu_ctrl_d;
            icu_div_q   <= icu_div_d;
            ctrim_q     <= ctrim_d;
            ftrim_q     <= ftrim_d;
            lolf_q      <= lolf_d;
            lock_prev_q <= lock_prev_d;
            trim_load_q <= trim_load_d;
        end
    end

    // ========================================
    // crystal oscillator enable and stabilisation
    csc_pkg::csc_osc_state_t osc_st_q, osc_st_d;
    logic [12:0] xcnt_q, xcnt_d;
    logic        xtl_prev_q, xtl_prev_d;
    logic        osc_en, init_done;

    assign osc_en = req_s || (osc_ctrl_q[csc_pkg::OSC_EN_BIT] &&
                    (!stop_s || osc_ctrl_q[csc_pkg::OSC_STEN_BIT]));
    assign init_done = (osc_st_q == csc_pkg::CSC_OSC_STABLE) ||
                       (osc_st_q == csc_pkg::CSC_OSC_EXT);

    // state machine counts rising crystal edges until stable
    always_comb begin
        osc_st_d   = osc_st_q;
        xcnt_d     = xcnt_q;
        xtl_prev_d = xtl_s;
        unique case (osc_st_q)
            csc_pkg::CSC_OSC_OFF: begin
                xcnt_d = 13'h0000;
                if (osc_en)
                    osc_st_d = osc_ctrl_q[csc_pkg::OSC_OS_BIT] ? csc_pkg::CSC_OSC_START
                                                               : csc_pkg::CSC_OSC_EXT;
            end
            csc_pkg::CSC_OSC_START: begin
                if (xtl_s && !xtl_prev_q)
                    xcnt_d = xcnt_q + 13'h0001;
                if (xcnt_q == 13'(csc_pkg::CRYSTAL_DRIVE_PIN_STABLE_COUNT))
                    osc_st_d = csc_pkg::CSC_OSC_STABLE;
            end
            csc_pkg::CSC_OSC_STABLE: ;
            csc_pkg::CSC_OSC_EXT: ;
        endcase
        if (!osc_en) begin
            osc_st_d = csc_pkg::CSC_OSC_OFF;
            xcnt_d   = 13'h0000;
        end
    end

    always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
        if (RST_IN) begin
            osc_st_q   <= csc_pkg::CSC_OSC_OFF;
            xcnt_q     <= 13'h0000;
            xtl_prev_q <= 1'b0;
        end else begin
            osc_st_q   <= osc_st_d;
            xcnt_q     <= xcnt_d;
            xtl_prev_q <= xtl_prev_d;
        end
    end

    // ========================================
    // clock gating and status outputs, all registered
    logic xout_d, iref_d, main_d, ffc_d, ffv_d, ext_ref_d, rst_req_d, irq_d;
    logic iref_on;

    // stop keeps the reference only with both enables
    assign iref_on = icu_ctrl_q[csc_pkg::ICU_REFCKEN_BIT] &&
                     (!stop_s || icu_ctrl_q[csc_pkg::ICU_REFSTOP_BIT]);

    always_comb begin
        // oscillator output is static low when disabled or unstable
        unique case (osc_st_q)
            csc_pkg::CSC_OSC_STABLE: xout_d = xtl_s;
            csc_pkg::CSC_OSC_EXT:    xout_d = pin_s;
            default:                 xout_d = 1'b0;
        endcase
        iref_d = iref_on && iref_s;
        // trimmed reference reaches main clock in internal bypass modes
        unique case (mode)
            csc_pkg::CSC_BPI, csc_pkg::CSC_BPILP: main_d = iref_s;
            csc_pkg::CSC_BPE, csc_pkg::CSC_BPELP: main_d = xout_d;
            default:                             main_d = fll_s;
        endcase
        ext_ref_d = (mode == csc_pkg::CSC_ENE) || (mode == csc_pkg::CSC_BPE);
        ffv_d     = ffok_s;
        ffc_d     = ffok_s && ffc_s;
        rst_req_d = icu_ctrl_q[csc_pkg::ICU_MON_BIT] && slow_s &&
                    ((mode == csc_pkg::CSC_BPE) || (mode == csc_pkg::CSC_ENE) ||
                     (mode == csc_pkg::CSC_BPELP));
        irq_d     = lolf_q && icu_ctrl_q[csc_pkg::ICU_LLIRQ_BIT];
    end

    // read mux; unmapped addresses read zero
    always_comb begin
        rdata_d = 8'h00;
        if (RD_IN) begin
            unique case (ADDR_IN)
                csc_pkg::OSC_CTRL_ADDR:  rdata_d = {osc_ctrl_q[7:1], init_done};
                csc_pkg::ICU_CTRL_ADDR:  rdata_d = icu_ctrl_q;
                csc_pkg::ICU_DIV_ADDR:   rdata_d = icu_div_q;
                csc_pkg::ICU_CTRIM_ADDR: rdata_d = ctrim_q;
                csc_pkg::ICU_FTRIM_ADDR: rdata_d = {7'h00, ftrim_q};
                csc_pkg::ICU_STAT_ADDR:  rdata_d = {lolf_q, lock_s, 6'h00};
                default:                 rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
        if (RST_IN) begin
            RDATA_OUT                  <= 8'h00;
            CRYSTAL_CLOCK_OUT          <= 1'b0;
            CRYSTAL_DRIVE_PIN_OUT      <= 1'b0;
            CRYSTAL_DRIVE_PIN_OE_N_OUT <= 1'b1;
            CRYSTAL_HIGH_GAIN_OUT      <= 1'b0;
            CRYSTAL_HIGH_BAND_OUT      <= 1'b0;
            INTERNAL_REF_CLOCK_OUT     <= 1'b0;
            MAIN_CLOCK_OUT             <= 1'b0;
            FIXED_FREQ_CLOCK_OUT       <= 1'b0;
            FIXED_FREQ_VALID_OUT       <= 1'b0;
            LOCK_REF_EXTERNAL_OUT      <= 1'b0;
            INT_REF_COARSE_TRIM_OUT    <= csc_pkg::FACTORY_CTRIM_DEFAULT;
            INT_REF_FINE_TRIM_OUT      <= csc_pkg::FACTORY_FTRIM_DEFAULT;
            BUS_DIVIDER_OUT            <= 3'h0;
            REF_DIVIDER_OUT            <= 3'h0;
            LOSS_OF_LOCK_IRQ_OUT       <= 1'b0;
            CHIP_RESET_REQ_OUT         <= 1'b0;
        end else begin
            RDATA_OUT                  <= rdata_d;
            CRYSTAL_CLOCK_OUT          <= xout_d;
            // drive pin only in crystal mode; pin free as I/O otherwise
            CRYSTAL_DRIVE_PIN_OUT      <= ~xtl_s;
            CRYSTAL_DRIVE_PIN_OE_N_OUT <= ~(osc_en && osc_ctrl_q[csc_pkg::OSC_OS_BIT]);
            CRYSTAL_HIGH_GAIN_OUT      <= osc_ctrl_q[csc_pkg::OSC_GAIN_BIT];
            CRYSTAL_HIGH_BAND_OUT      <= osc_ctrl_q[csc_pkg::OSC_RANGE_BIT];
            INTERNAL_REF_CLOCK_OUT     <= iref_d;
            MAIN_CLOCK_OUT             <= main_d;
            FIXED_FREQ_CLOCK_OUT       <= ffc_d;
            FIXED_FREQ_VALID_OUT       <= ffv_d;
            LOCK_REF_EXTERNAL_OUT      <= ext_ref_d;
            INT_REF_COARSE_TRIM_OUT    <= ctrim_q;
            INT_REF_FINE_TRIM_OUT      <= ftrim_q;
            BUS_DIVIDER_OUT            <= icu_div_q[2:0];
            REF_DIVIDER_OUT            <= icu_div_q[5:3];
            LOSS_OF_LOCK_IRQ_OUT       <= irq_d;
            CHIP_RESET_REQ_OUT         <= rst_req_d;
        end
    end

endmodule
